// ---- common/phy_status_cfg.svh ----
`ifndef PHY_STATUS_CFG_SVH
`define PHY_STATUS_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define QSTAT_IDX 8'h10
`define FCC_IDX 8'h14
`define REC_IDX 8'h15
`define ANX_IDX 8'h06
`define TEN_IDX 8'h0a
`define ISTAT_IDX 8'h18
`define IEN_IDX 8'h19
`define ICLR_IDX 8'h1a

// APB address width and word alignment.
`define PADDR_W 8
`define WORD_LSB 2

// Field positions inside the quick status word.
`define QS_RSVD_HI 15
`define QS_RSVD_LO 14
`define QS_RXERR_BIT 13
`define QS_POL_BIT 12
`define QS_FC_BIT 11
`define QS_SD_BIT 10
`define QS_LOCK_BIT 9
`define QS_PAGE_BIT 8

// Field positions in the mirrored source registers.
`define TEN_POL_BIT 4
`define ANX_PAGE_BIT 1

// Interrupt status, enable and clear layout.
`define IRQ_W 6
`define IRQ_RXERR 0
`define IRQ_FC 1
`define IRQ_POL 2
`define IRQ_SDLOST 3
`define IRQ_LOCKLOST 4
`define IRQ_PAGE 5

// Reset values.
`define DATA_RST 32'h0000_0000
`define IRQ_RST 6'h00

`endif

// ---- common/phy_status_pkg.sv ----
package phy_status_pkg;

    // Which register an APB address selects.
    typedef enum {
        SEL_NONE,
        SEL_QSTAT,
        SEL_FCC,
        SEL_REC,
        SEL_ANX,
        SEL_TEN,
        SEL_ISTAT,
        SEL_IEN,
        SEL_ICLR
    } reg_sel_t;

endpackage

// ---- rtl/in_sync.sv ----
module in_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous levels in, filtered levels out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    // A zero width would leave nothing to synchronise.
    if (WIDTH < 1)
    begin : g_bad_width
        $error("in_sync WIDTH must be at least one");
    end

    // Each bit updates only when the second and third stages agree.
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.s1 = async_in;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (state_r.s2[i] == state_r.s3[i])
            begin
                state_nxt.out[i] = state_r.s3[i];
            end
        end
    end

    // The first stage feeds only the second one, as metastability demands.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign sync_out = state_r.out;

endmodule

// ---- rtl/phy_status_upper_bits.sv ----
// Overview of operation
// R1 - Quick status bits 15 and 14 always read zero; writes to them are dropped.
// R2 - Bit 13 latches on receive error, cleared only by reading receive error counter.
// R3 - Bit 12 mirrors ten meg polarity bit 4; cleared only by that register's read.
// R4 - Bit 11 latches on false carrier, cleared only by reading false carrier counter.
// R5 - Bit 10 gives 100 Mb/s signal detect latched low, reset value zero.
// R6 - Bit 9 gives 100 Mb/s descrambler lock latched low, reset value zero.
// R7 - Bit 8 mirrors expansion page received; only expansion register read clears it.
// R8 - Page received flag sets on link code word, clears on expansion read.
// R9 - A dropped latched-low bit stays zero until quick status read, then follows live.
`include "phy_status_cfg.svh"

module phy_status_upper_bits #(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event pulses from logic on this clock.
    input wire logic rx_error_evt,
    input wire logic false_carrier_evt,
    input wire logic page_code_word_evt,
    // Live levels from the analog front end, asynchronous.
    input wire logic polarity_inverted,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    // Interrupt.
    output logic irq
);

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic rxerr_latch;
        logic fc_latch;
        logic pol_latch;
        logic sd_ll;
        logic lock_ll;
        logic page_rx;
        logic [CNT_W-1:0] rxerr_cnt;
        logic [CNT_W-1:0] fc_cnt;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_en;
        logic irq;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic pol_live;
    logic sd_live;
    logic lock_live;
    logic access;
    logic done;
    logic rd_qstat;
    logic rd_fcc;
    logic rd_rec;
    logic rd_anx;
    logic rd_ten;
    phy_status_pkg::reg_sel_t rd_sel;
    phy_status_pkg::reg_sel_t wr_sel;

    // Counters must fit the 32-bit data word.
    if (CNT_W < 1 || CNT_W > 32)
    begin : g_bad_cnt
        $error("CNT_W must lie between 1 and 32");
    end

    // Maps an APB byte address to a register; misaligned addresses map nowhere.
    function automatic phy_status_pkg::reg_sel_t decode(input logic [`PADDR_W-1:0] a);
        logic [`PADDR_W-1:0] idx;
        idx = a >> `WORD_LSB;
        if (a[`WORD_LSB-1:0] != '0)
        begin
            return phy_status_pkg::SEL_NONE;
        end
        case (idx)
            `QSTAT_IDX: return phy_status_pkg::SEL_QSTAT;
            `FCC_IDX: return phy_status_pkg::SEL_FCC;
            `REC_IDX: return phy_status_pkg::SEL_REC;
            `ANX_IDX: return phy_status_pkg::SEL_ANX;
            `TEN_IDX: return phy_status_pkg::SEL_TEN;
            `ISTAT_IDX: return phy_status_pkg::SEL_ISTAT;
            `IEN_IDX: return phy_status_pkg::SEL_IEN;
            `ICLR_IDX: return phy_status_pkg::SEL_ICLR;
            default: return phy_status_pkg::SEL_NONE;
        endcase
    endfunction

    // Saturating increment, so a long burst never wraps back to a small count.
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
        if (c == '1)
        begin
            return c;
        end
        return c + 1'b1;
    endfunction

    // Front-end levels come from another timing domain.
    in_sync #(
        .WIDTH(3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({polarity_inverted, signal_detect, descrambler_lock}),
        .sync_out({pol_live, sd_live, lock_live})
    );

    // The first access cycle takes a read and its side effects; a write
    // lands at the completing edge, where the master samples pready high.
    assign access = psel && penable && !state_r.pready;
    assign done = psel && penable && state_r.pready;
    assign rd_sel = decode(paddr);
    assign wr_sel = decode(paddr);
    assign rd_qstat = access && !pwrite && rd_sel == phy_status_pkg::SEL_QSTAT;
    assign rd_fcc = access && !pwrite && rd_sel == phy_status_pkg::SEL_FCC;
    assign rd_rec = access && !pwrite && rd_sel == phy_status_pkg::SEL_REC;
    assign rd_anx = access && !pwrite && rd_sel == phy_status_pkg::SEL_ANX;
    assign rd_ten = access && !pwrite && rd_sel == phy_status_pkg::SEL_TEN;

    // Next-state logic; in every latch the clear comes first so that an
    // event in the clearing cycle still sets the bit.
    always_comb
    begin
        logic [`IRQ_W-1:0] ev;
        logic [`IRQ_W-1:0] clr;
        logic [31:0] rd;
        ev = '0;
        clr = '0;
        rd = `DATA_RST;
        state_nxt = state_r;

        // Receive error latch and its counter.
        if (rd_rec)
        begin
            state_nxt.rxerr_latch = 1'b0; // R2
            state_nxt.rxerr_cnt = '0;
        end
        if (rx_error_evt)
        begin
            state_nxt.rxerr_latch = 1'b1; // R2
            state_nxt.rxerr_cnt = sat_inc(state_nxt.rxerr_cnt);
            ev[`IRQ_RXERR] = 1'b1;
        end

        // False carrier latch and its counter.
        if (rd_fcc)
        begin
            state_nxt.fc_latch = 1'b0; // R4
            state_nxt.fc_cnt = '0;
        end
        if (false_carrier_evt)
        begin
            state_nxt.fc_latch = 1'b1; // R4
            state_nxt.fc_cnt = sat_inc(state_nxt.fc_cnt);
            ev[`IRQ_FC] = 1'b1;
        end

        // Polarity stays flagged while the pair is still inverted at the read.
        if (rd_ten)
        begin
            state_nxt.pol_latch = 1'b0; // R3
        end
        if (pol_live)
        begin
            state_nxt.pol_latch = 1'b1; // R3
            ev[`IRQ_POL] = !state_r.pol_latch;
        end

        // Latched-low indications; a read re-arms them onto the live level.
        if (rd_qstat)
        begin
            state_nxt.sd_ll = sd_live; // R5 R9
            state_nxt.lock_ll = lock_live; // R6 R9
        end
        else
        begin
            state_nxt.sd_ll = state_r.sd_ll && sd_live; // R5 R9
            state_nxt.lock_ll = state_r.lock_ll && lock_live; // R6 R9
        end
        ev[`IRQ_SDLOST] = state_r.sd_ll && !state_nxt.sd_ll;
        ev[`IRQ_LOCKLOST] = state_r.lock_ll && !state_nxt.lock_ll;

        // Page received: a quick status read deliberately leaves it alone.
        if (rd_anx)
        begin
            state_nxt.page_rx = 1'b0; // R7 R8
        end
        if (page_code_word_evt)
        begin
            state_nxt.page_rx = 1'b1; // R8
            ev[`IRQ_PAGE] = 1'b1;
        end

        // Read multiplexer; the upper reserved bits are never assigned.
        case (rd_sel)
            phy_status_pkg::SEL_QSTAT:
            begin
                rd[`QS_RXERR_BIT] = state_r.rxerr_latch; // R2
                rd[`QS_POL_BIT] = state_r.pol_latch; // R3
                rd[`QS_FC_BIT] = state_r.fc_latch; // R4
                rd[`QS_SD_BIT] = state_r.sd_ll; // R5
                rd[`QS_LOCK_BIT] = state_r.lock_ll; // R6
                rd[`QS_PAGE_BIT] = state_r.page_rx; // R7
            end
            phy_status_pkg::SEL_FCC: rd[CNT_W-1:0] = state_r.fc_cnt;
            phy_status_pkg::SEL_REC: rd[CNT_W-1:0] = state_r.rxerr_cnt;
            phy_status_pkg::SEL_ANX: rd[`ANX_PAGE_BIT] = state_r.page_rx;
            phy_status_pkg::SEL_TEN: rd[`TEN_POL_BIT] = state_r.pol_latch;
            phy_status_pkg::SEL_ISTAT: rd[`IRQ_W-1:0] = state_r.irq_stat;
            phy_status_pkg::SEL_IEN: rd[`IRQ_W-1:0] = state_r.irq_en;
            default: rd = `DATA_RST;
        endcase

        // Bus answer: one wait state, then a one-cycle pready.
        state_nxt.pready = access;
        state_nxt.pslverr = access && rd_sel == phy_status_pkg::SEL_NONE;
        state_nxt.prdata = (access && !pwrite) ? rd : `DATA_RST;

        // Writes; status, counters and mirrors are read only and drop data.
        if (done && pwrite)
        begin
            case (wr_sel)
                phy_status_pkg::SEL_IEN: state_nxt.irq_en = pwdata[`IRQ_W-1:0];
                phy_status_pkg::SEL_ICLR: clr = pwdata[`IRQ_W-1:0];
                default: clr = '0; // R1
            endcase
        end

        // Sticky interrupt status, with the set winning over the clear.
        state_nxt.irq_stat = (state_r.irq_stat & ~clr) | ev;
        state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_en);
    end

    // All state in one register; reset gives constants only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign prdata = state_r.prdata;
    assign pready = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign irq = state_r.irq;

    // Reserved quick status bits never reach the bus.
    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // R1
        rd_qstat |=> prdata[`QS_RSVD_HI:`QS_RSVD_LO] == 2'h0 && prdata[31:16] == 16'h0000)
        else $error("reserved quick status bits read non-zero");

    // A receive error shows up in the next quick status word.
    a_rxerr_set: assert property (@(posedge pclk) disable iff (!presetn) // R2
        rx_error_evt |=> state_r.rxerr_latch && state_r.irq_stat[`IRQ_RXERR])
        else $error("receive error did not latch");

    // Only a receive error counter read may drop the receive error latch.
    a_rxerr_hold: assert property (@(posedge pclk) disable iff (!presetn) // R2
        state_r.rxerr_latch && !rd_rec |=> state_r.rxerr_latch)
        else $error("receive error latch dropped without counter read");

    // Quick status bit 12 reads back the polarity latch as it stood in the access cycle.
    a_pol_mirror: assert property (@(posedge pclk) disable iff (!presetn) // R3
        rd_qstat ##1 (psel && penable && pready) |-> prdata[`QS_POL_BIT] == $past(state_r.pol_latch))
        else $error("polarity mirror differs from its latch");

    // Polarity latch survives everything but a ten meg register read.
    a_pol_hold: assert property (@(posedge pclk) disable iff (!presetn) // R3
        state_r.pol_latch && !rd_ten |=> state_r.pol_latch)
        else $error("polarity bit cleared without ten meg read");

    // A clean false carrier counter read clears both the latch and the count.
    a_fc_clear: assert property (@(posedge pclk) disable iff (!presetn) // R4
        rd_fcc && !false_carrier_evt |=> !state_r.fc_latch ##0 state_r.fc_cnt == '0)
        else $error("false carrier read did not clear latch and count");

    // A dropped signal detect stays low until the quick status read.
    a_sd_low_hold: assert property (@(posedge pclk) disable iff (!presetn) // R5 R9
        !state_r.sd_ll && !rd_qstat |=> !state_r.sd_ll)
        else $error("signal detect rose without a quick status read");

    // After a quick status read the lock indication re-arms and follows live.
    a_lock_rearm: assert property (@(posedge pclk) disable iff (!presetn) // R6 R9
        rd_qstat |=> state_r.lock_ll == $past(lock_live))
        else $error("lock indication did not re-arm on read");

    // Page received is untouched by quick status reads.
    a_page_kept: assert property (@(posedge pclk) disable iff (!presetn) // R7
        state_r.page_rx && !rd_anx |=> state_r.page_rx)
        else $error("page received cleared without expansion read");

    // A link code word sets page received within one cycle.
    a_page_set: assert property (@(posedge pclk) disable iff (!presetn) // R8
        page_code_word_evt |=> state_r.page_rx && state_r.irq_stat[`IRQ_PAGE])
        else $error("link code word did not set page received");

    // Pready is a single-cycle answer two cycles after the setup phase.
    a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 psel && penable |=> pready ##1 !pready)
        else $error("pready timing broken");

endmodule

// ---- bench/phy_status_upper_bits_bench.sv ----
`include "phy_status_cfg.svh"

module phy_status_upper_bits_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [2:0] evt;
    logic pol_inv;
    logic sig_det;
    logic lock;
    logic [31:0] rd;
    logic err;
    int errors;
    int n_checks;
    int cycles;

    phy_status_upper_bits #(.CNT_W(8)) u_phy_status_upper_bits (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_error_evt(evt[0]),
        .false_carrier_evt(evt[1]),
        .page_code_word_evt(evt[2]),
        .polarity_inverted(pol_inv),
        .signal_detect(sig_det),
        .descrambler_lock(lock),
        .irq(irq)
    );

    // Free running 10 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Byte address of a register index; the low two bits stay zero.
    function automatic logic [7:0] ad(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the cycle timeout below ends a wait that never completes.
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    // Read, mask and compare in one call.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        check(rd & m, exp);
        check({31'h0, err}, 32'h0);
    endtask

    // Refused address: error flagged and no data returned.
    task automatic bad_chk(input logic w, input logic [7:0] a);
        apb(w, a, 32'hffff_ffff, rd, err);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt[i] <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // A hang ends the run as a failure rather than stalling it.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {evt, pol_inv, sig_det, lock} = '0;
        errors = 0;
        n_checks = 0;
        cycles = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ad(`QSTAT_IDX), 32'hffff_ffff, 32'h0);
        rd_chk(ad(`IEN_IDX), 32'hffff_ffff, 32'h0);
        // The bus answer stands one cycle only, then drops back to zero.
        idle(1);
        check({30'h0, pready, pslverr}, 32'h0);
        check(prdata, 32'h0);
        wr(ad(`QSTAT_IDX), 32'hffff_ffff);
        rd_chk(ad(`QSTAT_IDX), 32'hffff_ffff, 32'h0);
        // Receive errors; the status read itself must not clear the latch.
        pulse(0);
        pulse(0);
        rd_chk(ad(`QSTAT_IDX), 32'h2000, 32'h2000);
        rd_chk(ad(`QSTAT_IDX), 32'h2000, 32'h2000);
        rd_chk(ad(`REC_IDX), 32'hff, 32'h2);
        rd_chk(ad(`QSTAT_IDX), 32'h2000, 32'h0);
        // False carrier; the wrong counter read leaves it set.
        pulse(1);
        rd_chk(ad(`REC_IDX), 32'hff, 32'h0);
        rd_chk(ad(`QSTAT_IDX), 32'h2800, 32'h0800);
        rd_chk(ad(`FCC_IDX), 32'hff, 32'h1);
        rd_chk(ad(`QSTAT_IDX), 32'h0800, 32'h0);
        // Page received mirror.
        pulse(2);
        rd_chk(ad(`QSTAT_IDX), 32'h0100, 32'h0100);
        rd_chk(ad(`QSTAT_IDX), 32'h0100, 32'h0100);
        rd_chk(ad(`ANX_IDX), 32'h2, 32'h2);
        rd_chk(ad(`QSTAT_IDX), 32'h0100, 32'h0);
        rd_chk(ad(`ANX_IDX), 32'h2, 32'h0);
        // Polarity held until the ten meg register is read.
        pol_inv <= 1'b1;
        idle(8);
        pol_inv <= 1'b0;
        idle(8);
        rd_chk(ad(`QSTAT_IDX), 32'h1000, 32'h1000);
        rd_chk(ad(`QSTAT_IDX), 32'h1000, 32'h1000);
        rd_chk(ad(`TEN_IDX), 32'h10, 32'h10);
        rd_chk(ad(`QSTAT_IDX), 32'h1000, 32'h0);
        // Interrupt: clear all, mask one event, raise and clear another.
        wr(ad(`ICLR_IDX), 32'h3f);
        rd_chk(ad(`ISTAT_IDX), 32'h3f, 32'h0);
        wr(ad(`IEN_IDX), 32'h1);
        rd_chk(ad(`IEN_IDX), 32'h3f, 32'h1);
        pulse(1);
        idle(2);
        check({31'h0, irq}, 32'h0);
        rd_chk(ad(`ISTAT_IDX), 32'h3f, 32'h2);
        pulse(0);
        idle(2);
        check({31'h0, irq}, 32'h1);
        rd_chk(ad(`ICLR_IDX), 32'hffff_ffff, 32'h0);
        wr(ad(`ICLR_IDX), 32'h1);
        idle(1);
        check({31'h0, irq}, 32'h0);
        rd_chk(ad(`ISTAT_IDX), 32'h3f, 32'h2);
        bad_chk(1'b0, ad(8'h1f));
        bad_chk(1'b1, ad(8'h1f));
        bad_chk(1'b0, 8'h41);
        // Latched-low bits hold a drop until the status read, then follow live.
        sig_det <= 1'b1;
        lock <= 1'b1;
        idle(8);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0600);
        sig_det <= 1'b0;
        idle(8);
        sig_det <= 1'b1;
        idle(8);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0200);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0600);
        lock <= 1'b0;
        idle(8);
        lock <= 1'b1;
        idle(8);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0400);
        rd_chk(ad(`QSTAT_IDX), 32'h0600, 32'h0600);
        rd_chk(ad(`ISTAT_IDX), 32'h18, 32'h18);
        close_out();
    end
endmodule
